// ### hdl/fdsc_pkg.sv
/*
 * Constants, codes and state types of the flash and debug security control.
 * Assumes one 40 MHz clock and that flash, debug and nonvolatile logic share it.
 */
// What this block does
// - debug circuitry active after reset when the store holds open level, debug not off
// - only firmware may switch debug off
// - debug returns only via mass erase
// - factory state is open, no restrictions
// - user may move open to protected
// - protected level refuses debug port accesses except mass erase
// - protected returns open only after full erase
// - user may move open directly to kill
// - kill level blocks every debug access
// - kill level rejects external erase commands
// - kill level can never be left
// - per row write and read protection
// - system calls always reach the flash
// - kill disables programming, debug, test interfaces
package fdsc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int ROW_W  = 5;
    localparam int ROWS   = 32;
    localparam int CNT_W  = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ROW_WP  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ROW_RP  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BLOCKED = 8'h14;

    // field positions
    localparam int CTRL_DBG_OFF = 0;
    localparam int ST_DBG_EN    = 0;
    localparam int ST_TEST_EN   = 1;
    localparam int ST_BUSY      = 2;
    localparam int ST_DBG_OFF   = 3;
    localparam int ST_LVL_LSB   = 4;

    // reset values
    localparam logic [ROWS-1:0]  ROW_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // nonvolatile level codes
    localparam logic [1:0] LVL_OPEN = 2'h0;
    localparam logic [1:0] LVL_PROT = 2'h1;
    localparam logic [1:0] LVL_KILL = 2'h2;

    // flash operation codes
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;
    localparam logic [1:0] OP_MASS  = 2'h3;

    typedef enum logic [3:0] {
        LV_BOOT = 4'h1,
        LV_OPEN = 4'h2,
        LV_PROT = 4'h4,
        LV_KILL = 4'h8
    } fdsc_lvl_t;

    typedef enum logic [2:0] {
        OPS_IDLE = 3'h1,
        OPS_SYS  = 3'h2,
        OPS_DBG  = 3'h4
    } fdsc_ops_t;
endpackage : fdsc_pkg

// ### hdl/fdsc_top.sv
/*
 * Flash and debug security control: protection level, debug gating,
 * per-row protection and arbitration of flash operations.
 * Assumes the flash, debug protocol logic and nonvolatile latches run on SYS_CLK.
 */
`timescale 1ns/1ps
module fdsc_top (
    // clock and reset
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST_B,
    // firmware register port
    input  wire logic [fdsc_pkg::ADDR_W-1:0]   REG_ADDR,
    input  wire logic [fdsc_pkg::DATA_W-1:0]   REG_WDATA,
    input  wire logic                          REG_WR,
    input  wire logic                          REG_RD,
    output logic      [fdsc_pkg::DATA_W-1:0]   REG_RDATA,
    // nonvolatile level store
    input  wire logic [1:0]                    NV_LEVEL,
    input  wire logic                          NV_DBG_OFF,
    output logic                               NV_WR,
    output logic      [1:0]                    NV_WLEVEL,
    output logic                               NV_WDBG_OFF,
    // system call path
    input  wire logic                          SYS_REQ,
    input  wire logic [1:0]                    SYS_OP,
    input  wire logic [fdsc_pkg::ROW_W-1:0]    SYS_ROW,
    input  wire logic [fdsc_pkg::DATA_W-1:0]   SYS_WDATA,
    output logic                               SYS_RDY,
    output logic                               SYS_DONE,
    output logic      [fdsc_pkg::DATA_W-1:0]   SYS_RDATA,
    // debug port requests
    input  wire logic                          DBG_REQ,
    input  wire logic [1:0]                    DBG_OP,
    input  wire logic [fdsc_pkg::ROW_W-1:0]    DBG_ROW,
    input  wire logic [fdsc_pkg::DATA_W-1:0]   DBG_WDATA,
    output logic                               DBG_RDY,
    output logic                               DBG_DONE,
    output logic                               DBG_ERR,
    output logic      [fdsc_pkg::DATA_W-1:0]   DBG_RDATA,
    // flash macro
    output logic                               FL_REQ,
    output logic      [1:0]                    FL_OP,
    output logic      [fdsc_pkg::ROW_W-1:0]    FL_ROW,
    output logic      [fdsc_pkg::DATA_W-1:0]   FL_WDATA,
    input  wire logic                          FL_DONE,
    input  wire logic [fdsc_pkg::DATA_W-1:0]   FL_RDATA,
    // interface enables and level
    output logic                               DBG_EN,
    output logic                               TEST_EN,
    output logic      [1:0]                    PROT_LEVEL
);
    import fdsc_pkg::*;

    fdsc_lvl_t              level;
    fdsc_lvl_t              next_level;
    fdsc_ops_t              ops;
    logic                   dbg_off;
    logic                   next_dbg_off;
    logic [ROWS-1:0]        row_wp;
    logic [ROWS-1:0]        row_rp;
    logic [CNT_W-1:0]       blocked_cnt;
    logic [1:0]             cur_op;
    logic                   mass_done;
    logic                   sys_take;
    logic                   dbg_take;
    logic                   dbg_ok;
    logic                   wr_ctrl;
    logic                   wr_level;
    logic                   wr_wp;
    logic                   wr_rp;

    // nonvolatile code to state, unknown codes fail safe to kill
    function automatic fdsc_lvl_t lvl_decode(input logic [1:0] code);
        if (code == LVL_OPEN) begin
            return LV_OPEN;
        end else if (code == LVL_PROT) begin
            return LV_PROT;
        end
        return LV_KILL;
    endfunction : lvl_decode

    // state to nonvolatile code
    function automatic logic [1:0] lvl_encode(input fdsc_lvl_t lv);
        if (lv == LV_OPEN) begin
            return LVL_OPEN;
        end else if (lv == LV_PROT) begin
            return LVL_PROT;
        end
        return LVL_KILL;
    endfunction : lvl_encode

    // permission check for one debug port operation
    function automatic logic dbg_permit(
        input fdsc_lvl_t       lv,
        input logic            off,
        input logic [1:0]      op,
        input logic [ROW_W-1:0] row,
        input logic [ROWS-1:0] wp,
        input logic [ROWS-1:0] rp
    );
        logic ok;
        ok = 1'b0;
        unique case (lv)
            LV_OPEN: begin
                if (op == OP_MASS) begin
                    ok = 1'b1;
                end else if (off) begin
                    ok = 1'b0;
                end else if (op == OP_READ) begin
                    ok = !rp[row];
                end else begin
                    ok = !wp[row];
                end
            end
            LV_PROT: ok = (op == OP_MASS);
            LV_KILL: ok = 1'b0;
            LV_BOOT: ok = 1'b0;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : dbg_permit

    // register write decode
    assign wr_ctrl  = REG_WR && (REG_ADDR == OFS_CTRL);
    assign wr_level = REG_WR && (REG_ADDR == OFS_LEVEL);
    assign wr_wp    = REG_WR && (REG_ADDR == OFS_ROW_WP);
    assign wr_rp    = REG_WR && (REG_ADDR == OFS_ROW_RP);

    // request acceptance, system calls first
    assign SYS_RDY  = (ops == OPS_IDLE) && (level != LV_BOOT);
    assign DBG_RDY  = (ops == OPS_IDLE) && (level != LV_BOOT) && !SYS_REQ;
    assign sys_take = SYS_RDY && SYS_REQ;
    assign dbg_take = DBG_RDY && DBG_REQ;
    assign dbg_ok   = dbg_permit(level, dbg_off, DBG_OP, DBG_ROW, row_wp, row_rp);
    assign mass_done = FL_DONE && (ops != OPS_IDLE) && (cur_op == OP_MASS);

    // next protection level
    always_comb begin
        next_level = level;
        unique case (level)
            LV_BOOT: next_level = lvl_decode(NV_LEVEL);
            LV_OPEN: begin
                if (wr_level && REG_WDATA[1:0] == LVL_PROT) begin
                    next_level = LV_PROT;
                end else if (wr_level && REG_WDATA[1:0] == LVL_KILL) begin
                    next_level = LV_KILL;
                end
            end
            LV_PROT: begin
                if (mass_done) begin
                    next_level = LV_OPEN;
                end
            end
            LV_KILL: next_level = LV_KILL;
            default: next_level = LV_KILL;
        endcase
    end

    // next debug-off flag, firmware set wins over erase clear
    always_comb begin
        next_dbg_off = dbg_off;
        if (level == LV_BOOT) begin
            next_dbg_off = NV_DBG_OFF;
        end else if (wr_ctrl && REG_WDATA[CTRL_DBG_OFF]) begin
            next_dbg_off = 1'b1;
        end else if (mass_done) begin
            next_dbg_off = 1'b0;
        end
    end

    // level and debug-off state, loaded from the store after release
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            level   <= LV_BOOT;
            dbg_off <= 1'b0;
        end else begin
            level   <= next_level;
            dbg_off <= next_dbg_off;
        end
    end

    // write back changes to the nonvolatile store
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            NV_WR       <= 1'b0;
            NV_WLEVEL   <= LVL_OPEN;
            NV_WDBG_OFF <= 1'b0;
        end else begin
            NV_WR       <= (level != LV_BOOT) &&
                           ((next_level != level) || (next_dbg_off != dbg_off));
            NV_WLEVEL   <= lvl_encode(next_level);
            NV_WDBG_OFF <= next_dbg_off;
        end
    end

    // row protection, firmware write wins over erase clear
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            row_wp <= ROW_RST;
            row_rp <= ROW_RST;
        end else begin
            if (wr_wp) begin
                row_wp <= REG_WDATA[ROWS-1:0];
            end else if (mass_done) begin
                row_wp <= ROW_RST;
            end
            if (wr_rp) begin
                row_rp <= REG_WDATA[ROWS-1:0];
            end else if (mass_done) begin
                row_rp <= ROW_RST;
            end
        end
    end

    // operation sequencer toward the flash
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ops      <= OPS_IDLE;
            cur_op   <= OP_READ;
            FL_REQ   <= 1'b0;
            FL_OP    <= OP_READ;
            FL_ROW   <= '0;
            FL_WDATA <= '0;
        end else begin
            FL_REQ <= 1'b0;
            unique case (ops)
                OPS_IDLE: begin
                    if (sys_take) begin
                        ops      <= OPS_SYS;
                        cur_op   <= SYS_OP;
                        FL_REQ   <= 1'b1;
                        FL_OP    <= SYS_OP;
                        FL_ROW   <= SYS_ROW;
                        FL_WDATA <= SYS_WDATA;
                    end else if (dbg_take && dbg_ok) begin
                        ops      <= OPS_DBG;
                        cur_op   <= DBG_OP;
                        FL_REQ   <= 1'b1;
                        FL_OP    <= DBG_OP;
                        FL_ROW   <= DBG_ROW;
                        FL_WDATA <= DBG_WDATA;
                    end
                end
                OPS_SYS, OPS_DBG: begin
                    if (FL_DONE) begin
                        ops <= OPS_IDLE;
                    end
                end
                default: ops <= OPS_IDLE;
            endcase
        end
    end

    // answers to the system call path
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SYS_DONE  <= 1'b0;
            SYS_RDATA <= '0;
        end else begin
            SYS_DONE <= (ops == OPS_SYS) && FL_DONE;
            if ((ops == OPS_SYS) && FL_DONE) begin
                SYS_RDATA <= FL_RDATA;
            end
        end
    end

    // answers to the debug port, refusals end at once with an error
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            DBG_DONE  <= 1'b0;
            DBG_ERR   <= 1'b0;
            DBG_RDATA <= '0;
        end else begin
            DBG_DONE <= ((ops == OPS_DBG) && FL_DONE) || (dbg_take && !dbg_ok);
            DBG_ERR  <= dbg_take && !dbg_ok;
            if ((ops == OPS_DBG) && FL_DONE) begin
                DBG_RDATA <= FL_RDATA;
            end else if (dbg_take) begin
                DBG_RDATA <= '0;
            end
        end
    end

    // count of refused debug accesses, saturating
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            blocked_cnt <= CNT_RST;
        end else if (dbg_take && !dbg_ok && (blocked_cnt != {CNT_W{1'b1}})) begin
            blocked_cnt <= blocked_cnt + 16'h0001;
        end
    end

    // interface enables and level outputs
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            DBG_EN     <= 1'b0;
            TEST_EN    <= 1'b0;
            PROT_LEVEL <= LVL_OPEN;
        end else begin
            DBG_EN     <= (next_level == LV_OPEN) && !next_dbg_off;
            TEST_EN    <= (next_level != LV_KILL);
            PROT_LEVEL <= lvl_encode(next_level);
        end
    end

    // register read, one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= '0;
            unique case (REG_ADDR)
                OFS_CTRL:    REG_RDATA[CTRL_DBG_OFF] <= dbg_off;
                OFS_LEVEL:   REG_RDATA[1:0] <= lvl_encode(level);
                OFS_STATUS: begin
                    REG_RDATA[ST_DBG_EN]  <= DBG_EN;
                    REG_RDATA[ST_TEST_EN] <= TEST_EN;
                    REG_RDATA[ST_BUSY]    <= (ops != OPS_IDLE);
                    REG_RDATA[ST_DBG_OFF] <= dbg_off;
                    REG_RDATA[ST_LVL_LSB +: 2] <= lvl_encode(level);
                end
                OFS_ROW_WP:  REG_RDATA[ROWS-1:0] <= row_wp;
                OFS_ROW_RP:  REG_RDATA[ROWS-1:0] <= row_rp;
                OFS_BLOCKED: REG_RDATA[CNT_W-1:0] <= blocked_cnt;
                default:     REG_RDATA <= '0;
            endcase
        end else begin
            REG_RDATA <= '0;
        end
    end
endmodule : fdsc_top

// ### verification/fdsc_flash_model.sv
/*
 * Flash macro and nonvolatile level store seen from the security block.
 * Assumes one clock; contents and stored level survive every reset.
 */
`timescale 1ns/1ps
module fdsc_flash_model (
    // clock and pace
    input  wire logic        clk,
    input  wire logic        slow,
    // flash side
    input  wire logic        req,
    input  wire logic [1:0]  op,
    input  wire logic [4:0]  row,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    // level store side
    input  wire logic        nv_wr,
    input  wire logic [1:0]  nv_wlevel,
    input  wire logic        nv_wdoff,
    output logic [1:0]       nv_level,
    output logic             nv_doff
);
    import fdsc_pkg::*;
    logic [31:0] mem [32];
    int          cnt;
    // factory contents, open level
    initial begin
        foreach (mem[i]) mem[i] = 32'ha5a5_0000 + 32'(i);
        {cnt, done, rdata, nv_level, nv_doff} = '0;
    end
    // answer after one or six cycles; read data churns when idle
    always @(posedge clk) begin
        done  <= 1'b0;
        rdata <= ~rdata;
        if (req) begin
            cnt <= slow ? 6 : 1;
        end else if (cnt == 1) begin
            done <= 1'b1;
            cnt  <= 0;
            if (op == OP_READ) rdata <= mem[row];
            if (op == OP_WRITE) mem[row] <= wdata;
            if (op == OP_ERASE) mem[row] <= 32'h0;
            if (op == OP_MASS) foreach (mem[i]) mem[i] <= 32'h0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    // level store keeps its value through reset
    always @(posedge clk) begin
        if (nv_wr) begin
            nv_level <= nv_wlevel;
            nv_doff  <= nv_wdoff;
        end
    end
endmodule : fdsc_flash_model

// ### verification/fdsc_assertions.sv
/*
 * Port assertions for fdsc_top.
 * Bound to every fdsc_top; single clock, reset active low.
 */
`timescale 1ns/1ps
module fdsc_chk (
    // clock and reset
    input wire logic                        SYS_CLK,
    input wire logic                        RST_B,
    // level store
    input wire logic [1:0]                  NV_LEVEL,
    input wire logic                        NV_DBG_OFF,
    input wire logic                        NV_WR,
    input wire logic [1:0]                  NV_WLEVEL,
    // requests
    input wire logic                        SYS_REQ,
    input wire logic                        SYS_RDY,
    input wire logic                        DBG_REQ,
    input wire logic [1:0]                  DBG_OP,
    input wire logic                        DBG_RDY,
    input wire logic                        DBG_DONE,
    input wire logic                        DBG_ERR,
    input wire logic [fdsc_pkg::DATA_W-1:0] DBG_RDATA,
    // flash and enables
    input wire logic                        FL_REQ,
    input wire logic [1:0]                  FL_OP,
    input wire logic                        FL_DONE,
    input wire logic                        DBG_EN,
    input wire logic                        TEST_EN,
    input wire logic [1:0]                  PROT_LEVEL
);
    import fdsc_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    logic dbg_take;
    // debug request accepted this edge
    assign dbg_take = DBG_REQ && DBG_RDY;
    a_boot_dbg_on: assert property (
        $rose(RST_B) && NV_LEVEL == LVL_OPEN && !NV_DBG_OFF |=> DBG_EN && TEST_EN && !NV_WR)
        else $error("debug not on after open boot");
    a_prot_refuse: assert property (
        dbg_take && PROT_LEVEL == LVL_PROT && DBG_OP != OP_MASS |=> DBG_DONE && DBG_ERR && !FL_REQ)
        else $error("protected debug access not refused");
    a_prot_mass: assert property (
        dbg_take && PROT_LEVEL == LVL_PROT && DBG_OP == OP_MASS |=> FL_REQ && FL_OP == OP_MASS)
        else $error("mass erase not passed in protected level");
    a_open_cause: assert property (
        PROT_LEVEL == LVL_OPEN && $past(PROT_LEVEL) == LVL_PROT
        |-> ($past(FL_DONE) || $past(FL_DONE, 2)) && FL_OP == OP_MASS)
        else $error("protected left without mass erase");
    a_kill_refuse: assert property (
        dbg_take && PROT_LEVEL == LVL_KILL
        |=> DBG_DONE && DBG_ERR && DBG_RDATA == '0 && !FL_REQ)
        else $error("debug access passed in kill level");
    a_kill_sticky: assert property (
        PROT_LEVEL == LVL_KILL |=> PROT_LEVEL == LVL_KILL)
        else $error("kill level left");
    a_kill_quiet: assert property (
        PROT_LEVEL == LVL_KILL |-> !DBG_EN && !TEST_EN)
        else $error("interfaces enabled in kill level");
    a_sys_serve: assert property (
        SYS_REQ && SYS_RDY |=> FL_REQ && !SYS_RDY && !DBG_RDY)
        else $error("system call not served");
    a_nv_track: assert property (
        PROT_LEVEL != $past(PROT_LEVEL) && $past(RST_B, 2)
        |-> NV_WR && NV_WLEVEL == PROT_LEVEL)
        else $error("level change not written to store");
endmodule : fdsc_chk
bind fdsc_top fdsc_chk u_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .NV_LEVEL(NV_LEVEL), .NV_DBG_OFF(NV_DBG_OFF),
    .NV_WR(NV_WR), .NV_WLEVEL(NV_WLEVEL), .SYS_REQ(SYS_REQ), .SYS_RDY(SYS_RDY),
    .DBG_REQ(DBG_REQ), .DBG_OP(DBG_OP), .DBG_RDY(DBG_RDY), .DBG_DONE(DBG_DONE),
    .DBG_ERR(DBG_ERR), .DBG_RDATA(DBG_RDATA), .FL_REQ(FL_REQ), .FL_OP(FL_OP),
    .FL_DONE(FL_DONE), .DBG_EN(DBG_EN), .TEST_EN(TEST_EN), .PROT_LEVEL(PROT_LEVEL)
);

// ### verification/tb_top.sv
/*
 * Self-checking bench for fdsc_top with the flash and level store model.
 * Assumes the package, design, model and checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import fdsc_pkg::*;
    logic        clk, rst_b, reg_wr, reg_rd, sys_req, dbg_req, slow, rd_seen;
    logic        nv_wr, nv_wdoff, nv_doff, fl_req, fl_done, sys_rdy, sys_done;
    logic        dbg_rdy, dbg_done, dbg_err, dbg_en, test_en;
    logic [1:0]  sys_op, dbg_op, nv_level, nv_wlevel, fl_op, prot_level;
    logic [4:0]  sys_row, dbg_row, fl_row, r;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, sys_wdata, sys_rdata, dbg_wdata, dbg_rdata;
    logic [31:0] fl_wdata, fl_rdata, w;
    logic [31:0] m [32];
    logic [33:0] dq[$], sq[$], rq[$];
    int          bad_count, checks;

    fdsc_top u_dut (
        .SYS_CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .NV_LEVEL(nv_level),
        .NV_DBG_OFF(nv_doff), .NV_WR(nv_wr), .NV_WLEVEL(nv_wlevel), .NV_WDBG_OFF(nv_wdoff),
        .SYS_REQ(sys_req), .SYS_OP(sys_op), .SYS_ROW(sys_row), .SYS_WDATA(sys_wdata),
        .SYS_RDY(sys_rdy), .SYS_DONE(sys_done), .SYS_RDATA(sys_rdata), .DBG_REQ(dbg_req),
        .DBG_OP(dbg_op), .DBG_ROW(dbg_row), .DBG_WDATA(dbg_wdata), .DBG_RDY(dbg_rdy),
        .DBG_DONE(dbg_done), .DBG_ERR(dbg_err), .DBG_RDATA(dbg_rdata), .FL_REQ(fl_req),
        .FL_OP(fl_op), .FL_ROW(fl_row), .FL_WDATA(fl_wdata), .FL_DONE(fl_done),
        .FL_RDATA(fl_rdata), .DBG_EN(dbg_en), .TEST_EN(test_en), .PROT_LEVEL(prot_level));
    fdsc_flash_model u_flash (
        .clk(clk), .slow(slow), .req(fl_req), .op(fl_op), .row(fl_row), .wdata(fl_wdata),
        .done(fl_done), .rdata(fl_rdata), .nv_wr(nv_wr), .nv_wlevel(nv_wlevel),
        .nv_wdoff(nv_wdoff), .nv_level(nv_level), .nv_doff(nv_doff));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // bit 33 asks for a data compare, bit 32 is the refusal flag
    task automatic cmp(input logic [33:0] e, input logic [32:0] g);
        checks++;
        if (g[32] !== e[32] || (e[33] && g[31:0] !== e[31:0])) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, e[32:0], g);
        end
    endtask : cmp
    // one compare for each kind of result, oldest note first
    task automatic cmp_dbg;
        cmp(dq.pop_front(), {dbg_err, dbg_rdata});
    endtask : cmp_dbg
    task automatic cmp_sys;
        cmp(sq.pop_front(), {1'b0, sys_rdata});
    endtask : cmp_sys
    task automatic cmp_reg;
        cmp(rq.pop_front(), {1'b0, reg_rdata});
    endtask : cmp_reg
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back({2'b10, x});
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic rst;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : rst
    // one flash operation from the debug port (d) or a system call
    task automatic op(input bit d, input logic [1:0] o, input logic [4:0] rw,
                      input logic [31:0] wd, input bit e);
        int n;
        n = 0;
        if (d) dq.push_back({e || o == OP_READ, e, e ? 32'h0 : m[rw]});
        else sq.push_back({o == OP_READ, 1'b0, m[rw]});
        @(posedge clk);
        {dbg_req, dbg_op, dbg_row, dbg_wdata} <= d ? {1'b1, o, rw, wd} : 40'h0;
        {sys_req, sys_op, sys_row, sys_wdata} <= d ? 40'h0 : {1'b1, o, rw, wd};
        @(negedge clk);
        while ((d ? dbg_rdy : sys_rdy) !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        dbg_req <= 1'b0;
        sys_req <= 1'b0;
        @(negedge clk);
        while ((d ? dbg_done : sys_done) !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (!e && o == OP_WRITE) m[rw] = wd;
        if (!e && o == OP_ERASE) m[rw] = 32'h0;
        if (!e && o == OP_MASS) foreach (m[i]) m[i] = 32'h0;
        if (n >= 100) begin
            bad_count++;
            close_out();
        end
    endtask : op
    // watch results and take the oldest note for each
    always @(posedge clk) begin
        if (dbg_done === 1'b1) cmp_dbg();
        if (sys_done === 1'b1) cmp_sys();
        if (rd_seen === 1'b1) cmp_reg();
        rd_seen <= reg_rd;
    end
    // main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, sys_req, dbg_req, slow, reg_addr, reg_wdata,
         sys_op, sys_row, sys_wdata, dbg_op, dbg_row, dbg_wdata} = '0;
        foreach (m[i]) m[i] = 32'ha5a5_0000 + 32'(i);
        w = $urandom(32'h12bb);
        r = 5'($urandom_range(31));
        w = $urandom;
        rst();
        rd(OFS_STATUS, 32'h3);
        rd(8'h18, 32'h0);
        $display("boot test done");
        slow <= 1'b1;
        op(1, OP_WRITE, r, w, 0);
        op(1, OP_READ, r, 0, 0);
        slow <= 1'b0;
        $display("open test done");
        wr(OFS_ROW_WP, 32'h1 << r);
        wr(OFS_ROW_RP, 32'h1 << r);
        op(1, OP_WRITE, r, ~w, 1);
        op(1, OP_READ, r, 0, 1);
        op(0, OP_WRITE, r, ~w, 0);
        op(0, OP_READ, r, 0, 0);
        rd(OFS_BLOCKED, 32'h2);
        $display("row test done");
        wr(OFS_CTRL, 32'h1);
        op(1, OP_READ, r, 0, 1);
        op(1, OP_ERASE, r, 0, 1);
        op(1, OP_MASS, 0, 0, 0);
        op(1, OP_READ, r, 0, 0);
        $display("debug off test done");
        wr(OFS_LEVEL, 32'h1);
        op(1, OP_READ, r, 0, 1);
        op(0, OP_WRITE, r, w, 0);
        rst();
        rd(OFS_LEVEL, 32'h1);
        op(1, OP_WRITE, r, 0, 1);
        op(1, OP_MASS, 0, 0, 0);
        rd(OFS_LEVEL, 32'h0);
        op(1, OP_READ, r, 0, 0);
        $display("protected test done");
        wr(OFS_LEVEL, 32'h3);
        rd(OFS_LEVEL, 32'h0);
        wr(OFS_LEVEL, 32'h2);
        rd(OFS_LEVEL, 32'h2);
        for (int k = 0; k < 4; k++) op(1, 2'(k), r, w, 1);
        wr(OFS_LEVEL, 32'h0);
        wr(OFS_LEVEL, 32'h1);
        op(0, OP_MASS, 0, 0, 0);
        rd(OFS_LEVEL, 32'h2);
        rst();
        rd(OFS_STATUS, 32'h20);
        repeat (3) @(posedge clk);
        $display("kill test done");
        close_out();
    end
endmodule : tb_top
